// *** src/ldc_consts.vh ***
// Constants of the LED dimming controller: offsets, codes, timing.
// Included by the dimming core; definitions only.
`ifndef LDC_CONSTS_VH
`define LDC_CONSTS_VH

// Register offsets on the write port
`define LDC_ADDR_LOW 8'h05
`define LDC_ADDR_HIGH 8'h06

// Clock rates and derived master tick divider
`define LDC_CLK_HZ 40000000
`define LDC_MCLK_KHZ 2857
`define LDC_MCLK_DIV (`LDC_CLK_HZ / (`LDC_MCLK_KHZ * 1000))

// Shortest controllable sink pulse, in master ticks (rounded up)
`define LDC_MIN_PULSE_NS 700
`define LDC_MIN_TICKS ((`LDC_MIN_PULSE_NS * `LDC_MCLK_KHZ + 999999) / 1000000)

// Brightness source select codes
`define LDC_SRC_PWM 2'h0
`define LDC_SRC_REG 2'h1
`define LDC_SRC_MUL 2'h2

// Output pulse rate select codes
`define LDC_RATE_2K79 3'h1
`define LDC_RATE_5K58 3'h2
`define LDC_RATE_11K2 3'h3
`define LDC_RATE_22K5 3'h4

// Output period exponents (period is 2^n master ticks) and the reset period
`define LDC_PBITS_2K79 4'hA
`define LDC_PBITS_5K58 4'h9
`define LDC_PBITS_11K2 4'h8
`define LDC_PBITS_22K5 4'h7
`define LDC_PER_RESET 11'h400

// Transition point: threshold is 2^(base + code) of 2^15 full scale
`define LDC_TP_BASE 4'hC
`define LDC_TP_FULL 2'h3
`define LDC_FULL_CODE 15'h7FFF

// Duty measurement resolution
`define LDC_DUTY_BITS 12
`define LDC_DUTY_MAX 12'hFFF
`define LDC_MEAS_MAX 16'hFFFF

`endif

// *** src/ldc_dimming.v ***
// LED dimming controller: brightness source, mapping, DC/PWM/hybrid sinks.
// Assumes a register write port fed by an external serial slave and
// a PWM input already synchronous to ref_clk_i.
//
// Contract
// - Style 0: steady DC level tracks brightness
// - Style 1: PWM below transition threshold
// - Phases spaced period over active string count
// - Four output rates, 2.79 to 22.32 kHz
// - Hybrid: DC above, PWM below switch point
// - Codes 11 and 10 thresholds and amplitudes
// - Codes 01 and 00 thresholds and amplitudes
// - Pulse width scales inversely with amplitude
// - Shortest on or off pulse 700 ns
// - Source 00: PWM input duty only
// - Source 01: register code, mapped
// - Low then high write commits value; with dither, high then low
// - Source 10: mapped code times duty
// - Linear mapping by default
// - Log curve bit selects logarithmic mapping
// - Dither forms 15-bit setting, fraction lowest
// - New intensity loaded at period start
// - Input measured on 2.857 MHz ticks
`timescale 1ns/100ps
`include "ldc_consts.vh"

module ldc_dimming (
	input wire ref_clk_i, // 40 MHz clock
	input wire sys_rst_i, // Async reset, active high
	input wire pwm_in_i, // Host PWM brightness input
	input wire reg_wr_i, // Register write strobe
	input wire [7:0] reg_addr_i, // Register address
	input wire [7:0] reg_wdata_i, // Register write data
	input wire dim_style_i, // 0 analog only, 1 PWM/hybrid
	input wire [1:0] pwm_transition_point_i, // Analog/PWM switch point
	input wire [2:0] output_pulse_rate_select_i, // Sink PWM rate
	input wire [1:0] brightness_source_select_i, // Brightness source
	input wire log_curve_i, // 1 selects log mapping
	input wire dither_en_i, // 1 adds 3 dither bits
	input wire [7:0] string_en_i, // Active strings
	output reg [7:0] reg_rdata_o, // Register read data
	output reg [7:0] sink_on_o, // Per-string sink gate
	output reg [14:0] sink_level_o, // Sink current amplitude
	output reg [11:0] pwm_duty_o // Measured input duty
);

	localparam ST_IDLE = 1'b0;
	localparam ST_DIV = 1'b1;

	// Macro counts are plain integers; cut them to the widths they meet
	localparam [31:0] DIV_LAST_W = `LDC_MCLK_DIV - 1;
	localparam [3:0] DIV_LAST = DIV_LAST_W[3:0];
	localparam [31:0] DUTY_LAST_W = `LDC_DUTY_BITS - 1;
	localparam [3:0] DUTY_LAST = DUTY_LAST_W[3:0];
	localparam [31:0] MIN_TICKS_W = `LDC_MIN_TICKS;
	localparam [10:0] MIN_TICKS = MIN_TICKS_W[10:0];

	function [14:0] ldc_map;
		input [14:0] x;
		input lg;
		reg [26:0] t;
		begin
			t = {15'h0, 1'b1, x[10:0]} << x[14:11];
			if (!lg)
				ldc_map = x;
			else if (x == 15'h0)
				ldc_map = 15'h0;
			else
				ldc_map = t[26:12];
		end
	endfunction

	function [3:0] ldc_cnt8;
		input [7:0] v;
		integer i;
		begin
			ldc_cnt8 = 4'h0;
			for (i = 0; i < 8; i = i + 1) begin
				ldc_cnt8 = ldc_cnt8 + {3'h0, v[i]};
			end
		end
	endfunction

	// Phase offset of string idx: its rank among active strings times the step
	function [10:0] ldc_ofs;
		input [7:0] en;
		input [2:0] idx;
		input [10:0] stp;
		reg [7:0] below;
		reg [14:0] p;
		begin
			below = en & ((8'h01 << idx) - 8'h01);
			p = {11'h000, ldc_cnt8(below)} * stp;
			ldc_ofs = p[10:0];
		end
	endfunction

	// Master tick divider
	reg [3:0] div_q;
	reg tick_q;

	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			div_q <= 4'h0;
			tick_q <= 1'b0;
		end else if (div_q == DIV_LAST) begin
			div_q <= 4'h0;
			tick_q <= 1'b1;
		end else begin
			div_q <= div_q + 4'h1;
			tick_q <= 1'b0;
		end
	end

	// Register staging and commit
	reg [7:0] lo_q;
	reg [7:0] hi_q;
	reg [14:0] code_q;
	wire wr_lo = reg_wr_i && (reg_addr_i == `LDC_ADDR_LOW);
	wire wr_hi = reg_wr_i && (reg_addr_i == `LDC_ADDR_HIGH);

	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			lo_q <= 8'h00;
			hi_q <= 8'h00;
			code_q <= 15'h0000;
			reg_rdata_o <= 8'h00;
		end else begin
			if (wr_lo) begin
				lo_q <= reg_wdata_i;
				if (dither_en_i)
					code_q <= {hi_q, reg_wdata_i[6:0]};
			end
			if (wr_hi) begin
				hi_q <= reg_wdata_i;
				if (!dither_en_i)
					code_q <= {reg_wdata_i, lo_q[3:0], 3'h0};
			end
			// Read data lags the address by one clock
			if (reg_addr_i == `LDC_ADDR_LOW)
				reg_rdata_o <= lo_q;
			else if (reg_addr_i == `LDC_ADDR_HIGH)
				reg_rdata_o <= hi_q;
			else
				reg_rdata_o <= 8'h00;
		end
	end

	// Input PWM measurement on master ticks
	reg pin_q;
	reg [15:0] hi_cnt_q;
	reg [15:0] per_cnt_q;
	reg st_q;
	reg [16:0] rem_q;
	reg [15:0] dvs_q;
	reg [11:0] quo_q;
	reg [3:0] bit_q;
	wire rise = tick_q && pwm_in_i && !pin_q;
	wire [16:0] rem_sh = {rem_q[15:0], 1'b0};
	wire rem_ge = rem_sh >= {1'b0, dvs_q};

	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pin_q <= 1'b0;
			hi_cnt_q <= 16'h0000;
			per_cnt_q <= 16'h0000;
			st_q <= ST_IDLE;
			rem_q <= 17'h00000;
			dvs_q <= 16'h0001;
			quo_q <= 12'h000;
			bit_q <= 4'h0;
			pwm_duty_o <= 12'h000;
		end else begin
			if (tick_q) begin
				pin_q <= pwm_in_i;
				if (rise) begin
					hi_cnt_q <= 16'h0001;
					per_cnt_q <= 16'h0001;
				end else begin
					if (per_cnt_q != `LDC_MEAS_MAX)
						per_cnt_q <= per_cnt_q + 16'h0001;
					else
						pwm_duty_o <= pwm_in_i ? `LDC_DUTY_MAX : 12'h000;
					if (pwm_in_i && hi_cnt_q != `LDC_MEAS_MAX)
						hi_cnt_q <= hi_cnt_q + 16'h0001;
				end
			end
			case (st_q)
				ST_IDLE: begin
					// An edge on the first tick after reset only starts the count; no duty yet
					if (rise && per_cnt_q != 16'h0000) begin
						if (hi_cnt_q >= per_cnt_q) begin
							pwm_duty_o <= `LDC_DUTY_MAX;
						end else begin
							rem_q <= {1'b0, hi_cnt_q};
							dvs_q <= per_cnt_q;
							bit_q <= 4'h0;
							st_q <= ST_DIV;
						end
					end
				end
				ST_DIV: begin
					// One quotient bit a clock; done well inside a tick
					if (rem_ge) begin
						rem_q <= rem_sh - {1'b0, dvs_q};
						quo_q <= {quo_q[10:0], 1'b1};
					end else begin
						rem_q <= rem_sh;
						quo_q <= {quo_q[10:0], 1'b0};
					end
					bit_q <= bit_q + 4'h1;
					if (bit_q == DUTY_LAST) begin
						pwm_duty_o <= {quo_q[10:0], rem_ge};
						st_q <= ST_IDLE;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// Brightness source and mapping
	reg [14:0] bright;
	wire [14:0] map_reg = ldc_map(code_q, log_curve_i);
	wire [14:0] map_pwm = ldc_map({pwm_duty_o, 3'h0}, log_curve_i);
	wire [26:0] prod = map_reg * pwm_duty_o;

	always @* begin
		case (brightness_source_select_i)
			`LDC_SRC_REG: bright = map_reg;
			`LDC_SRC_MUL: bright = prod[26:12];
			default: bright = map_pwm;
		endcase
	end

	// Output period in ticks
	reg [3:0] pbits;

	always @* begin
		case (output_pulse_rate_select_i)
			`LDC_RATE_5K58: pbits = `LDC_PBITS_5K58;
			`LDC_RATE_11K2: pbits = `LDC_PBITS_11K2;
			`LDC_RATE_22K5: pbits = `LDC_PBITS_22K5;
			// Unused codes fall back to the slowest rate
			default: pbits = `LDC_PBITS_2K79;
		endcase
	end

	wire [10:0] per_d = 11'h001 << pbits;
	wire [3:0] tp_sh = `LDC_TP_BASE + {2'h0, pwm_transition_point_i};
	wire [15:0] thr = 16'h0001 << tp_sh;
	wire tp_full = pwm_transition_point_i == `LDC_TP_FULL;

	// Dimming decision
	reg dc;
	reg [14:0] amp;
	reg [14:0] on_raw;
	reg [10:0] on_d;

	always @* begin
		dc = !dim_style_i || ({1'b0, bright} >= thr) ||
			(bright == `LDC_FULL_CODE);
		if (tp_full)
			amp = `LDC_FULL_CODE;
		else
			amp = thr[14:0];
		// Width is brightness over amplitude, in period ticks
		on_raw = bright >> (tp_sh - pbits);
		on_d = on_raw[10:0];
		if (dc) begin
			amp = bright;
			on_d = per_d;
		end else if (on_d != 11'h000 && on_d < MIN_TICKS) begin
			// Sink cannot resolve a shorter pulse, so stretch it
			on_d = MIN_TICKS;
		end else if (on_d != 11'h000 && per_d - on_d < MIN_TICKS) begin
			on_d = per_d - MIN_TICKS;
		end
	end

	// Phase spacing
	wire [3:0] n_act = ldc_cnt8(string_en_i);
	// No active strings: step is unused, but the divide must not see zero
	wire [10:0] step = (n_act == 4'h0) ? per_d : per_d / {7'h0, n_act};

	reg [10:0] cnt_q;
	reg [10:0] per_q;
	reg [10:0] on_q;
	reg [7:0] en_q;
	reg [10:0] ofs_q [0:7];
	wire bound = tick_q && (cnt_q == per_q - 11'h001);
	integer k;

	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_q <= 11'h000;
			per_q <= `LDC_PER_RESET;
			on_q <= 11'h000;
			en_q <= 8'h00;
			sink_level_o <= 15'h0000;
			for (k = 0; k < 8; k = k + 1) begin
				ofs_q[k] <= 11'h000;
			end
		end else if (bound) begin
			// Changes mid-period would tear a pulse, so all load here
			cnt_q <= 11'h000;
			per_q <= per_d;
			on_q <= on_d;
			sink_level_o <= amp;
			en_q <= string_en_i;
			for (k = 0; k < 8; k = k + 1) begin
				ofs_q[k] <= ldc_ofs(string_en_i, k[2:0], step);
			end
		end else if (tick_q) begin
			cnt_q <= cnt_q + 11'h001;
		end
	end

	// Per-string gating
	reg [7:0] on_d8;
	reg [10:0] ph;
	integer j;

	always @* begin
		on_d8 = 8'h00;
		ph = 11'h000;
		for (j = 0; j < 8; j = j + 1) begin
			// Period is a power of two, so the mask wraps the phase
			ph = (cnt_q - ofs_q[j]) & (per_q - 11'h001);
			on_d8[j] = en_q[j] && (ph < on_q);
		end
	end

	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			sink_on_o <= 8'h00;
		else
			sink_on_o <= on_d8;
	end

endmodule // ldc_dimming

// *** tb/ldc_dimming_properties.sv ***
// Port checker for the dimming core.
// Assumes bind to ldc_dimming; one clock domain.
`timescale 1ns/100ps
module ldc_dimming_properties (
	input wire ref_clk_i, // Clock
	input wire sys_rst_i, // Reset
	input wire reg_wr_i, // Write strobe
	input wire [7:0] reg_addr_i, // Address
	input wire [7:0] reg_wdata_i, // Write data
	input wire [7:0] reg_rdata_o, // Read data
	input wire [7:0] sink_on_o, // Gates
	input wire [14:0] sink_level_o, // Level
	input wire [11:0] pwm_duty_o // Duty
);
	logic [15:0] lvl_q, gate_q, duty_q;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	// Cycles since last change, saturating so reset never looks like a short gap
	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			lvl_q <= 16'hFFFF;
			gate_q <= 16'hFFFF;
			duty_q <= 16'hFFFF;
		end else begin
			lvl_q <= $changed(sink_level_o) ? 16'h0001 : lvl_q + {15'h0, lvl_q != 16'hFFFF};
			gate_q <= $changed(sink_on_o[0]) ? 16'h0001 : gate_q + {15'h0, gate_q != 16'hFFFF};
			duty_q <= $changed(pwm_duty_o) ? 16'h0001 : duty_q + {15'h0, duty_q != 16'hFFFF};
		end
	end
	reset_clear_a: assert property ($fell(sys_rst_i) |-> (sink_on_o == 8'h00)[*8])
		else $error("gates not clear after reset");
	unmapped_read_a: assert property (reg_addr_i != 8'h05 && reg_addr_i != 8'h06
		|=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
	high_readback_a: assert property (reg_wr_i && reg_addr_i == 8'h06 ##1 reg_addr_i == 8'h06
		|=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("high byte readback wrong");
	low_readback_a: assert property (reg_wr_i && reg_addr_i == 8'h05 ##1 reg_addr_i == 8'h05
		|=> reg_rdata_o[6:0] == $past(reg_wdata_i[6:0], 2)) else $error("low byte readback wrong");
	read_hold_a: assert property ((!reg_wr_i && $stable(reg_addr_i))[*2] |=> $stable(reg_rdata_o))
		else $error("read data moved");
	level_period_a: assert property ($changed(sink_level_o) |-> lvl_q >= 16'd1792)
		else $error("level changed inside a period");
	gate_pulse_a: assert property ($changed(sink_on_o[0]) |-> gate_q >= 16'd28)
		else $error("gate pulse shorter than minimum");
	duty_spacing_a: assert property ($changed(pwm_duty_o) |-> duty_q >= 16'd28)
		else $error("duty updated faster than sampling");
endmodule // ldc_dimming_properties
bind ldc_dimming ldc_dimming_properties u_props (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
	.reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.reg_rdata_o(reg_rdata_o), .sink_on_o(sink_on_o), .sink_level_o(sink_level_o),
	.pwm_duty_o(pwm_duty_o));

// *** tb/ldc_pwm_host.sv ***
// Host PWM source driving the brightness pin.
// Assumes a push-pull pin, so it always shows a driven level.
`timescale 1ns/100ps
module ldc_pwm_host #(
	parameter int ON = 896, // High clocks, whole master ticks
	parameter int PER = 3584 // Period clocks, whole master ticks
) (
	input wire ref_clk_i, // Clock
	output logic pwm_o // PWM pin
);
	int cnt = 0;
	initial pwm_o = 1'b0;
	always @(negedge ref_clk_i) begin
		cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
		pwm_o <= cnt < ON;
	end
endmodule // ldc_pwm_host

// *** tb/led_dimming_control_tb_top.sv ***
// Self-checking bench for the dimming core.
// Assumes ldc_pwm_host at 25 percent duty on the PWM pin.
`timescale 1ns/100ps
module led_dimming_control_tb_top;
	logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, dim_style_i = 1'b0;
	logic log_curve_i = 1'b0, dither_en_i = 1'b0, pwm_in_i;
	logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, string_en_i = 8'h0F;
	logic [1:0] tp = 2'h3, src = 2'h1;
	logic [2:0] rate = 3'h4;
	logic [14:0] thr, sx [4] = '{15'h2000, 15'h1E28, 15'h078A, 15'h2000};
	wire [7:0] rdata, gate;
	wire [14:0] level;
	wire [11:0] duty;
	int miscompares = 0, checks = 0, n, m;
	ldc_pwm_host u_host (.ref_clk_i(ref_clk_i), .pwm_o(pwm_in_i));
	ldc_dimming DUT (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .pwm_in_i(pwm_in_i),
		.reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.dim_style_i(dim_style_i), .pwm_transition_point_i(tp),
		.output_pulse_rate_select_i(rate), .brightness_source_select_i(src),
		.log_curve_i(log_curve_i), .dither_en_i(dither_en_i), .string_en_i(string_en_i),
		.reg_rdata_o(rdata), .sink_on_o(gate), .sink_level_o(level), .pwm_duty_o(duty));
	initial forever #12.5 ref_clk_i = ~ref_clk_i;
	task results();
		if (miscompares == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk_i);
		{reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, d};
		@(negedge ref_clk_i);
		reg_wr_i = 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge ref_clk_i);
		reg_addr_i = a;
		@(negedge ref_clk_i);
		chk(rdata, e);
	endtask
	// Cycles until gate b shows v; a lost gate ends the run
	task till(input int b, input logic v, output int c);
		c = 0;
		do begin
			@(negedge ref_clk_i);
			c++;
		end while (gate[b] !== v && c < 30000);
		if (c >= 30000) begin
			miscompares++;
			results();
		end
	endtask
	initial begin
		repeat (5) @(negedge ref_clk_i);
		sys_rst_i = 1'b0;
		wr(8'h05, 8'h25);
		wr(8'h06, 8'h3C);
		rd(8'h05, 8'h25);
		rd(8'h06, 8'h3C);
		rd(8'h07, 8'h00);
		repeat (14500) @(negedge ref_clk_i);
		chk(level, 15'h1E28);
		chk(gate, 8'h0F);
		dim_style_i = 1'b1;
		for (int t = 3; t >= 0; t--) begin
			tp = t;
			thr = (t == 3) ? 15'h7FFF : 15'h1000 << t;
			if (t == 0)
				repeat (3700) @(negedge ref_clk_i);
			else begin
				till(0, 1'b0, n);
				till(0, 1'b1, n);
			end
			chk(level, (15'h1E28 >= thr) ? 15'h1E28 : thr);
			if (t == 3) begin
				till(1, 1'b1, n);
				chk(n, 16'd448);
				till(0, 1'b0, n);
				till(0, 1'b1, n);
			end
			if (t != 0) begin
				till(0, 1'b0, n);
				chk(n, 16'd14 * (16'h1E28 >> (5 + t)));
			end
		end
		{dim_style_i, tp} = {1'b0, 2'h3};
		for (int s = 0; s < 4; s++) begin
			src = s;
			repeat (3700) @(negedge ref_clk_i);
			chk(level, sx[s]);
		end
		chk(duty, 12'h400);
		{src, dither_en_i} = {2'h1, 1'b1};
		wr(8'h06, 8'h3C);
		wr(8'h05, 8'h5B);
		repeat (3700) @(negedge ref_clk_i);
		chk(level, 15'h1E5B);
		log_curve_i = 1'b1;
		repeat (3700) @(negedge ref_clk_i);
		chk(level, 15'h0007);
		log_curve_i = 1'b0;
		wr(8'h06, 8'h02);
		wr(8'h05, 8'h00);
		dim_style_i = 1'b1;
		till(0, 1'b0, n);
		till(0, 1'b1, n);
		till(0, 1'b0, n);
		chk(n, 16'd28);
		for (int r = 4; r >= 1; r--) begin
			rate = r;
			till(0, 1'b0, n);
			till(0, 1'b1, n);
			till(0, 1'b0, n);
			till(0, 1'b1, m);
			chk(n + m, 16'd14 * (16'd1024 >> (r - 1)));
		end
		results();
	end
endmodule // led_dimming_control_tb_top
